// ### hw/irq_power_pkg.sv
// Offsets, bit positions and reset values of the flag and power registers
package irq_power_pkg;

	localparam logic [7:0] FLAGS_OFFSET = 8'h0c;
	localparam logic [7:0] POWER_OFFSET = 8'h8e;

	localparam int TIMER_ONE_BIT = 0;
	localparam int TIMER_TWO_BIT = 1;
	localparam int OSC_FAIL_BIT = 2;
	localparam int COMPARATOR_BIT = 3;
	localparam int UNUSED_FLAG_BIT = 4;
	localparam int CAPTURE_BIT = 5;
	localparam int CONVERSION_BIT = 6;
	localparam int EEPROM_BIT = 7;

	localparam logic [7:0] FLAGS_MASK = 8'hef;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	localparam int BROWNOUT_BIT = 0;
	localparam int POWER_ON_BIT = 1;
	localparam int SOFT_BROWNOUT_BIT = 4;
	localparam int ULTRA_WAKE_BIT = 5;

	localparam logic POWER_ON_RESET = 1'b0;
	localparam logic BROWNOUT_RESET = 1'b0;
	localparam logic SOFT_BROWNOUT_RESET = 1'b1;
	localparam logic ULTRA_WAKE_RESET = 1'b0;

	localparam logic [1:0] CONFIG_SOFTWARE = 2'h1;
	localparam logic [1:0] CONFIG_OFF = 2'h0;

	localparam int SYNC_STAGES = 3;

endpackage

// ### hw/irq_power_regs.sv
// Peripheral interrupt flag register and power control register
//
// The strobed register port was decided locally.
module irq_power_regs
	import irq_power_pkg::*;
#(
	parameter int ADDRESS_WIDTH = 8
)
(
	// Clock and power-on reset
	input wire logic i_clock,
	input wire logic i_reset,
	// Register port
	input wire logic [ADDRESS_WIDTH-1:0] i_address,
	input wire logic [7:0] i_write_data,
	input wire logic i_write_strobe,
	input wire logic i_read_strobe,
	output logic [7:0] o_read_data,
	// Peripheral event pulses
	input wire logic i_timer_one_overflow,
	input wire logic i_timer_two_match,
	input wire logic i_oscillator_fail,
	input wire logic i_comparator_change,
	input wire logic i_capture_compare,
	input wire logic i_conversion_done,
	input wire logic i_eeprom_write_done,
	// Brown-out detector and configuration
	input wire logic i_brownout_detected,
	input wire logic [1:0] i_brownout_config_field,
	// Status towards the core
	output logic [7:0] o_peripheral_irq_flags,
	output logic o_ultra_low_wake_enable,
	output logic o_brownout_detect_enable
);

	// Refuse address widths that cannot hold the offsets
	if (ADDRESS_WIDTH < 8)
	begin : g_address_width_check
		$error("ADDRESS_WIDTH must be at least 8");
	end

	typedef struct packed {
		logic [7:0] flags;
		logic ultra_low_wake_enable;
		logic soft_brownout_enable;
		logic power_on_flag;
		logic brownout_flag;
		logic [SYNC_STAGES-1:0] brownout_sync;
		logic brownout_level;
		logic brownout_seen;
		logic detect_enable;
		logic [7:0] read_data;
	} state_type;

	state_type state;
	state_type next_state;

	function automatic logic [7:0] power_image(input state_type s);
		logic [7:0] v;
		v = 8'h00;
		v[ULTRA_WAKE_BIT] = s.ultra_low_wake_enable;
		v[SOFT_BROWNOUT_BIT] = s.soft_brownout_enable;
		v[POWER_ON_BIT] = s.power_on_flag;
		v[BROWNOUT_BIT] = s.brownout_flag;
		return v;
	endfunction

	function automatic logic detect_on(input logic [1:0] cfg, input logic soft_bit);
		logic on;
		on = 1'b1;
		if (cfg == CONFIG_SOFTWARE)
			on = soft_bit;
		else if (cfg == CONFIG_OFF)
			on = 1'b0;
		return on;
	endfunction

	logic [7:0] events;
	logic flags_hit;
	logic power_hit;
	logic brownout_event;

	always_comb
	begin
		events = 8'h00;
		events[TIMER_ONE_BIT] = i_timer_one_overflow;
		events[TIMER_TWO_BIT] = i_timer_two_match;
		events[OSC_FAIL_BIT] = i_oscillator_fail;
		events[COMPARATOR_BIT] = i_comparator_change;
		events[CAPTURE_BIT] = i_capture_compare;
		events[CONVERSION_BIT] = i_conversion_done;
		events[EEPROM_BIT] = i_eeprom_write_done;
		flags_hit = i_address == ADDRESS_WIDTH'(FLAGS_OFFSET);
		power_hit = i_address == ADDRESS_WIDTH'(POWER_OFFSET);
		brownout_event = state.brownout_seen && state.detect_enable;
	end

	always_comb
	begin
		next_state = state;
		// Three-stage synchroniser; level counts when stages two and three agree
		next_state.brownout_sync = {state.brownout_sync[SYNC_STAGES-2:0], i_brownout_detected};
		if (state.brownout_sync[1] == state.brownout_sync[2])
			next_state.brownout_level = state.brownout_sync[2];
		// One pulse per rising agreed level, however long the pin stays high
		next_state.brownout_seen = next_state.brownout_level && !state.brownout_level;
		next_state.detect_enable = detect_on(i_brownout_config_field, state.soft_brownout_enable);
		// Flags: software write first, hardware set on top
		if (i_write_strobe && flags_hit)
			next_state.flags = i_write_data & FLAGS_MASK;
		next_state.flags = (next_state.flags | events) & FLAGS_MASK;
		if (i_write_strobe && power_hit)
		begin
			next_state.ultra_low_wake_enable = i_write_data[ULTRA_WAKE_BIT];
			next_state.soft_brownout_enable = i_write_data[SOFT_BROWNOUT_BIT];
			next_state.power_on_flag = i_write_data[POWER_ON_BIT];
			next_state.brownout_flag = i_write_data[BROWNOUT_BIT];
		end
		if (brownout_event)
			next_state.brownout_flag = 1'b0;
		next_state.read_data = 8'h00;
		if (i_read_strobe && flags_hit)
			next_state.read_data = state.flags & FLAGS_MASK;
		else if (i_read_strobe && power_hit)
			next_state.read_data = power_image(state);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			state <= '0;
			state.flags <= FLAGS_RESET;
			state.ultra_low_wake_enable <= ULTRA_WAKE_RESET;
			state.soft_brownout_enable <= SOFT_BROWNOUT_RESET;
			state.power_on_flag <= POWER_ON_RESET;
			state.brownout_flag <= BROWNOUT_RESET;
		end
		else
			state <= next_state;
	end

	assign o_read_data = state.read_data;
	assign o_peripheral_irq_flags = state.flags;
	assign o_ultra_low_wake_enable = state.ultra_low_wake_enable;
	assign o_brownout_detect_enable = state.detect_enable;

	default clocking main_clock @(posedge i_clock);
	endclocking

	default disable iff (i_reset);

	sequence flag_write_s;
		i_write_strobe && flags_hit;
	endsequence

	sequence power_write_s;
		i_write_strobe && power_hit;
	endsequence

	sequence flags_read_s;
		i_read_strobe && flags_hit;
	endsequence

	sequence power_read_s;
		i_read_strobe && power_hit;
	endsequence

	// Timer 1 overflow shows next cycle
	timer_one_set_a: assert property (
		i_timer_one_overflow |=> o_peripheral_irq_flags[TIMER_ONE_BIT])
		else $error("timer 1 overflow flag not set");

	// Timer 1 flag holds without a write
	timer_one_hold_a: assert property (
		o_peripheral_irq_flags[TIMER_ONE_BIT] && !(i_write_strobe && flags_hit)
		|=> o_peripheral_irq_flags[TIMER_ONE_BIT])
		else $error("timer 1 flag dropped without a write");

	// Write of zero clears a flag with no event
	flag_clear_a: assert property (
		flag_write_s ##0 (events == 8'h00)
		|=> o_peripheral_irq_flags == ($past(i_write_data) & FLAGS_MASK))
		else $error("flag write not applied");

	// Event beats a clearing write
	set_wins_a: assert property (
		flag_write_s ##0 (events != 8'h00)
		|=> (o_peripheral_irq_flags & $past(events)) == $past(events))
		else $error("set event lost against a write");

	// Each event sets its flag, enables play no part
	flag_set_a: assert property (
		(events != 8'h00) |=> ((o_peripheral_irq_flags & $past(events)) == $past(events)))
		else $error("event did not set its flag");

	// Unused flag reads zero
	flag_unused_a: assert property (
		!o_peripheral_irq_flags[UNUSED_FLAG_BIT])
		else $error("unused flag bit set");

	// Power register read shows only implemented bits
	power_read_a: assert property (
		power_read_s |=> (o_read_data & 8'hcc) == 8'h00)
		else $error("unimplemented power bits read non-zero");

	// Flag register read returns the flags of the read cycle
	flags_read_a: assert property (
		flags_read_s |=> o_read_data == $past(state.flags))
		else $error("flag read data wrong");

	// Read data are zero outside the answer cycle
	read_idle_a: assert property (
		!i_read_strobe |=> o_read_data == 8'h00)
		else $error("read data outside answer cycle");

	// Power write sets the wake enable
	wake_write_a: assert property (
		power_write_s |=> o_ultra_low_wake_enable == $past(i_write_data[ULTRA_WAKE_BIT]))
		else $error("wake enable not written");

	// Software bit steers detection in mode 01 after a settled cycle
	soft_steer_a: assert property (
		(i_brownout_config_field == CONFIG_SOFTWARE) [*2]
		|=> o_brownout_detect_enable == $past(state.soft_brownout_enable))
		else $error("software enable did not steer detection");

	// Config off holds detection off
	config_off_a: assert property (
		(i_brownout_config_field == CONFIG_OFF) |=> !o_brownout_detect_enable)
		else $error("detection on with config off");

	// Power-on flag is zero right after reset
	power_on_clear_a: assert property (
		@(posedge i_clock) disable iff (1'b0)
		$fell(i_reset) |-> !state.power_on_flag)
		else $error("power-on flag not cleared by reset");

	// Brown-out pin pulse clears the flag within the synchroniser delay
	sequence brownout_rise_s;
		(!i_brownout_detected) [*3] ##1 i_brownout_detected [*5];
	endsequence

	sequence brownout_armed_s;
		o_brownout_detect_enable && !(i_write_strobe && power_hit);
	endsequence

	brownout_clear_a: assert property (
		brownout_rise_s ##0 brownout_armed_s
		##1 !(i_write_strobe && power_hit) |-> ##[0:2] !state.brownout_flag)
		else $error("brown-out did not clear its flag");

	// Soft brown-out bit resets to one
	soft_reset_a: assert property (
		@(posedge i_clock) disable iff (1'b0)
		$fell(i_reset) |-> state.soft_brownout_enable && !o_ultra_low_wake_enable)
		else $error("power control reset values wrong");

	sequence brownout_edge_s;
		state.brownout_seen && state.detect_enable;
	endsequence

	// Write of zero clears timer 1 flag with no overflow
	timer_one_clear_a: assert property (
		flag_write_s ##0 (!i_write_data[TIMER_ONE_BIT] && !i_timer_one_overflow)
		|=> !o_peripheral_irq_flags[TIMER_ONE_BIT])
		else $error("timer 1 flag not cleared by a write");

	// Flags hold without write or event
	flags_hold_a: assert property (
		!(i_write_strobe && flags_hit) && (events == 8'h00) |=> $stable(o_peripheral_irq_flags))
		else $error("flags changed without a cause");

	// Unused flag ignores a write of one
	unused_write_a: assert property (
		flag_write_s ##0 i_write_data[UNUSED_FLAG_BIT] |=> !o_peripheral_irq_flags[UNUSED_FLAG_BIT])
		else $error("unused flag took a write");

	// Unmapped read answers zero
	read_unmapped_a: assert property (
		i_read_strobe && !flags_hit && !power_hit |=> o_read_data == 8'h00)
		else $error("unmapped read not zero");

	// Power read shows the status and enable bits
	power_value_a: assert property (
		power_read_s |=> o_read_data[ULTRA_WAKE_BIT] == $past(state.ultra_low_wake_enable)
		&& o_read_data[SOFT_BROWNOUT_BIT] == $past(state.soft_brownout_enable)
		&& o_read_data[POWER_ON_BIT] == $past(state.power_on_flag)
		&& o_read_data[BROWNOUT_BIT] == $past(state.brownout_flag))
		else $error("power register read wrong");

	// Wake enable holds without a power write
	wake_hold_a: assert property (
		!(i_write_strobe && power_hit) |=> $stable(o_ultra_low_wake_enable))
		else $error("wake enable changed without a write");

	// Power write sets the soft brown-out bit
	soft_write_a: assert property (
		power_write_s |=> state.soft_brownout_enable == $past(i_write_data[SOFT_BROWNOUT_BIT]))
		else $error("soft brown-out bit not written");

	// Soft brown-out bit holds without a power write
	soft_hold_a: assert property (
		!(i_write_strobe && power_hit) |=> $stable(state.soft_brownout_enable))
		else $error("soft brown-out bit changed without a write");

	// Config 10 and 11 force detection on
	config_on_a: assert property (
		i_brownout_config_field[1] |=> o_brownout_detect_enable)
		else $error("detection off with config forced on");

	// Software sets the power-on flag by a write
	power_on_write_a: assert property (
		power_write_s |=> state.power_on_flag == $past(i_write_data[POWER_ON_BIT]))
		else $error("power-on flag not written");

	// Power-on flag holds without a power write
	power_on_hold_a: assert property (
		!(i_write_strobe && power_hit) |=> $stable(state.power_on_flag))
		else $error("power-on flag changed without a write");

	// Software sets the brown-out flag when no brown-out competes
	brownout_write_a: assert property (
		power_write_s ##0 !brownout_event |=> state.brownout_flag == $past(i_write_data[BROWNOUT_BIT]))
		else $error("brown-out flag not written");

	// Brown-out flag holds without a write or a brown-out
	brownout_hold_a: assert property (
		!(i_write_strobe && power_hit) && !brownout_event |=> $stable(state.brownout_flag))
		else $error("brown-out flag changed without a cause");

	// Detected brown-out beats a same-cycle software set
	clear_wins_a: assert property (
		brownout_edge_s |=> !state.brownout_flag)
		else $error("brown-out lost against a write");

	// Agreed level rise gives exactly one event pulse
	seen_edge_a: assert property (
		state.brownout_seen == $rose(state.brownout_level))
		else $error("brown-out pulse not on a level rise");

	// Event pulses are spaced by the synchroniser
	seen_single_a: assert property (
		state.brownout_seen |=> (!state.brownout_seen) [*3])
		else $error("brown-out pulse repeated");

endmodule // irq_power_regs

// ### tb/periph_irq_flags_power_status_tb.sv
// Self-checking bench for the peripheral flag and power control registers
module periph_irq_flags_power_status_tb
	import irq_power_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_address = 8'h00;
	logic [7:0] i_write_data = 8'h00;
	logic i_write_strobe = 1'b0;
	logic i_read_strobe = 1'b0;
	logic [6:0] ev = 7'h00;
	logic i_brownout_detected = 1'b0;
	logic [1:0] i_brownout_config_field = 2'h1;
	wire logic [7:0] o_read_data;
	wire logic [7:0] o_peripheral_irq_flags;
	wire logic o_ultra_low_wake_enable;
	wire logic o_brownout_detect_enable;
	logic [7:0] acc = 8'h00;
	int n_errors = 0;
	int checks_done = 0;

	irq_power_regs #(.ADDRESS_WIDTH(8)) u_irq_power_regs (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_address(i_address),
		.i_write_data(i_write_data),
		.i_write_strobe(i_write_strobe),
		.i_read_strobe(i_read_strobe),
		.o_read_data(o_read_data),
		.i_timer_one_overflow(ev[0]),
		.i_timer_two_match(ev[1]),
		.i_oscillator_fail(ev[2]),
		.i_comparator_change(ev[3]),
		.i_capture_compare(ev[4]),
		.i_conversion_done(ev[5]),
		.i_eeprom_write_done(ev[6]),
		.i_brownout_detected(i_brownout_detected),
		.i_brownout_config_field(i_brownout_config_field),
		.o_peripheral_irq_flags(o_peripheral_irq_flags),
		.o_ultra_low_wake_enable(o_ultra_low_wake_enable),
		.o_brownout_detect_enable(o_brownout_detect_enable)
	);

	always #2 i_clock = ~i_clock;

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Write, optionally with event pulses in the same cycle
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [6:0] e);
		@(posedge i_clock);
		i_address <= a;
		i_write_data <= d;
		i_write_strobe <= 1'b1;
		ev <= e;
		@(posedge i_clock);
		i_write_strobe <= 1'b0;
		ev <= 7'h00;
	endtask

	// Read and compare the data of the following cycle
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_address <= a;
		i_read_strobe <= 1'b1;
		@(posedge i_clock);
		i_read_strobe <= 1'b0;
		#1 check(o_read_data, exp);
	endtask

	task pulse(input logic [6:0] e);
		@(posedge i_clock);
		ev <= e;
		@(posedge i_clock);
		ev <= 7'h00;
	endtask

	task brownout_event;
		@(posedge i_clock);
		i_brownout_detected <= 1'b1;
		repeat (8) @(posedge i_clock);
		i_brownout_detected <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask

	initial
	begin
		#10000;
		n_errors++;
		end_sim;
	end

	initial
	begin
		repeat (12) @(posedge i_clock);
		i_reset <= 1'b0;
		rd(FLAGS_OFFSET, FLAGS_RESET);
		rd(POWER_OFFSET, 8'h10);
		check({7'h00, o_brownout_detect_enable}, 8'h01);
		rd(8'h0d, 8'h00);
		$display("test reset_values done");
		wr(POWER_OFFSET, 8'hff, 7'h00);
		rd(POWER_OFFSET, 8'h33);
		@(posedge i_clock);
		#1 check(o_read_data, 8'h00);
		check({7'h00, o_ultra_low_wake_enable}, 8'h01);
		wr(POWER_OFFSET, 8'h03, 7'h00);
		rd(POWER_OFFSET, 8'h03);
		check({7'h00, o_ultra_low_wake_enable}, 8'h00);
		check({7'h00, o_brownout_detect_enable}, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			@(posedge i_clock);
			i_brownout_config_field <= c[1:0];
			repeat (2) @(posedge i_clock);
			#1 check({7'h00, o_brownout_detect_enable}, (c >= 2) ? 8'h01 : 8'h00);
		end
		@(posedge i_clock);
		i_brownout_config_field <= CONFIG_SOFTWARE;
		wr(8'h0d, 8'hff, 7'h00);
		rd(POWER_OFFSET, 8'h03);
		rd(FLAGS_OFFSET, 8'h00);
		$display("test power_register done");
		for (int i = 0; i < 7; i++)
		begin
			pulse(7'h01 << i);
			acc = acc | (8'h01 << ((i < 4) ? i : i + 1));
			#1 check(o_peripheral_irq_flags, acc);
		end
		rd(FLAGS_OFFSET, 8'hef);
		wr(FLAGS_OFFSET, 8'h00, 7'h01);
		rd(FLAGS_OFFSET, 8'h01);
		wr(FLAGS_OFFSET, 8'h00, 7'h00);
		rd(FLAGS_OFFSET, 8'h00);
		wr(FLAGS_OFFSET, 8'h10, 7'h00);
		rd(FLAGS_OFFSET, 8'h00);
		$display("test flags done");
		wr(POWER_OFFSET, 8'h13, 7'h00);
		brownout_event;
		rd(POWER_OFFSET, 8'h12);
		wr(POWER_OFFSET, 8'h03, 7'h00);
		repeat (3) @(posedge i_clock);
		brownout_event;
		rd(POWER_OFFSET, 8'h03);
		@(posedge i_clock);
		i_brownout_config_field <= 2'h2;
		brownout_event;
		rd(POWER_OFFSET, 8'h02);
		pulse(7'h7f);
		#1 check(o_peripheral_irq_flags, 8'hef);
		@(posedge i_clock);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_reset <= 1'b0;
		rd(POWER_OFFSET, 8'h10);
		rd(FLAGS_OFFSET, FLAGS_RESET);
		$display("test brownout_and_reset done");
		end_sim;
	end
endmodule // periph_irq_flags_power_status_tb
